/* include/block_framing_consts.svh */
// named constants of the contactless block framer
// assumes inclusion by bare name; guarded against double inclusion
`ifndef BLOCK_FRAMING_CONSTS_SVH
`define BLOCK_FRAMING_CONSTS_SVH
// ----------------------------------------
// frame check
// ----------------------------------------
`define CRC_PRESET 16'h6363
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'h0000
`define CRC_BYTES 4'h2
// ----------------------------------------
// protocol control byte layout
// ----------------------------------------
`define PCB_I_MASK 8'hf6
`define PCB_I_VAL 8'h02
`define PCB_R_MASK 8'he6
`define PCB_R_VAL 8'ha2
`define PCB_S_MASK 8'hc7
`define PCB_S_VAL 8'hc2
`define PCB_NAK_BIT 4
`define PCB_DID_BIT 3
`define PCB_BN_BIT 0
`define PCB_S_TYPE_MSB 5
`define PCB_S_TYPE_LSB 4
`define S_TYPE_DES 2'h0
`define S_TYPE_WTX 2'h3
`define PCB_ACK_NODID 8'ha2
`define PCB_NAK_NODID 8'hb2
`define PCB_DES_NODID 8'hc2
`define PCB_WTX_NODID 8'hf2
`define HDR_NODID 4'h1
`define HDR_DID 4'h2
`define WTX_LEN 4'h1
`define WTX_MULT_MASK 8'h3f
`define TX_LEN_ONE 2'h1
`define TX_LEN_TWO 2'h2
// ----------------------------------------
// timing and buffering
// ----------------------------------------
`define FWT_BASE_US 19200
`define CLK_MHZ 50
`define FWI_DEFAULT 4'h7
`define RX_BUF_DEPTH 3
`define RX_CNT_MAX 4'hf
`endif

/* include/block_framing_pkg.sv */
// types and shared decode functions of the block framer
// assumes the consts header is on the include path
package block_framing_pkg;
`include "block_framing_consts.svh"

   typedef enum logic [2:0] {
      KIND_NONE = 3'b000,
      KIND_I = 3'b001,
      KIND_ACK = 3'b010,
      KIND_NAK = 3'b011,
      KIND_DES = 3'b100,
      KIND_WTX = 3'b101
   } kind_t;

   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b00,
      ST_WTX_WAIT = 2'b01,
      ST_STANDBY = 2'b10
   } tag_state_t;

   typedef logic [7:0] byte_t;

   // reflected crc, one byte lsb first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input byte_t d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // plen counts pcb, did and payload bytes
   function automatic kind_t decode_pcb(input byte_t pcb, input logic [3:0] plen);
      logic [3:0] hdr;
      logic [1:0] styp;
      hdr = pcb[`PCB_DID_BIT] ? `HDR_DID : `HDR_NODID;
      styp = pcb[`PCB_S_TYPE_MSB:`PCB_S_TYPE_LSB];
      if (((pcb & `PCB_I_MASK) == `PCB_I_VAL) && (plen >= hdr))
         return KIND_I;
      else if (((pcb & `PCB_R_MASK) == `PCB_R_VAL) && (plen == hdr))
         return pcb[`PCB_NAK_BIT] ? KIND_NAK : KIND_ACK;
      else if (((pcb & `PCB_S_MASK) == `PCB_S_VAL) && (styp == `S_TYPE_DES) && (plen == hdr))
         return KIND_DES;
      else if (((pcb & `PCB_S_MASK) == `PCB_S_VAL) && (styp == `S_TYPE_WTX)
               && (plen == hdr + `WTX_LEN))
         return KIND_WTX;
      else
         return KIND_NONE;
   endfunction

   function automatic byte_t wtx_field(input byte_t pcb, input byte_t b1, input byte_t b2);
      return pcb[`PCB_DID_BIT] ? b2 : b1;
   endfunction
endpackage

/* include/block_link_if.sv */
// byte-wide link between the tag end and the reader end
// assumes both ends share one clock; no back-pressure on the link
`timescale 1ns/100ps
interface block_link_if;
   logic [7:0] r2t_data;
   logic r2t_valid;
   logic r2t_last;
   logic [7:0] t2r_data;
   logic t2r_valid;
   logic t2r_last;

   modport tag (
      input r2t_data,
      input r2t_valid,
      input r2t_last,
      output t2r_data,
      output t2r_valid,
      output t2r_last
   );

   modport reader (
      output r2t_data,
      output r2t_valid,
      output r2t_last,
      input t2r_data,
      input t2r_valid,
      input t2r_last
   );
endinterface

/* design/block_tx.sv */
// frame transmitter: up to three header bytes, then two crc bytes
// assumes i_start only while o_busy is low
`timescale 1ns/100ps
`include "block_framing_consts.svh"
module block_tx (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [1:0] i_len,
   input wire logic [7:0] i_b0,
   input wire logic [7:0] i_b1,
   input wire logic [7:0] i_b2,
   output logic [7:0] o_data,
   output logic o_valid,
   output logic o_last,
   output logic o_busy
);
   logic [7:0] buf_reg [0:2];
   logic [2:0] idx_reg;
   logic [2:0] len_reg;
   logic [15:0] crc_reg;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_busy <= 1'b0;
         o_valid <= 1'b0;
         o_last <= 1'b0;
         o_data <= 8'h00;
         idx_reg <= 3'h0;
         len_reg <= 3'h0;
         crc_reg <= `CRC_PRESET;
         buf_reg <= '{8'h00, 8'h00, 8'h00};
      end
      else if (i_ce)
      begin
         if (!o_busy)
         begin
            o_valid <= 1'b0;
            o_last <= 1'b0;
            if (i_start)
            begin
               o_busy <= 1'b1;
               idx_reg <= 3'h0;
               len_reg <= {1'b0, i_len};
               buf_reg <= '{i_b0, i_b1, i_b2};
               crc_reg <= `CRC_PRESET;
            end
         end
         else if (idx_reg < len_reg)
         begin
            o_data <= buf_reg[idx_reg[1:0]];
            crc_reg <= block_framing_pkg::crc_byte(crc_reg, buf_reg[idx_reg[1:0]]);
            o_valid <= 1'b1;
            idx_reg <= idx_reg + 3'h1;
         end
         else if (idx_reg == len_reg)
         begin
            // no final inversion, low byte first
            o_data <= crc_reg[7:0];
            idx_reg <= idx_reg + 3'h1;
         end
         else
         begin
            o_data <= crc_reg[15:8];
            o_last <= 1'b1;
            o_busy <= 1'b0;
         end
      end
   end
endmodule // block_tx

/* design/tag_end.sv */
// tag end of the block framer: r and s block handling, wtx timing, crc
// assumes the i-block path drives I_CMD_BUSY while a command runs;
// reset is applied at each rf activation
//
// Function
// - r-block pcb: 10 1 x x 0 1 bn
// - ack from both; nak from reader only
// - tag accepts and originates ack blocks
// - s-block pcb: 11 tt x 0 1 0
// - s pcb values c2 ca f2 fa
// - wtx byte only in wtx s-blocks
// - request wtx when time exceeds base
// - extended delay is wtx times base
// - deselect releases session, enters standby
// - report default fwi to reader
// - request is pcb f2 plus wtx byte
// - reader echoes wtx block unchanged
// - extension holds for current command only
// - every frame ends in two crc bytes
// - crc covers data bytes, not crc
// - crc per sixteen-bit hdlc definition
// - crc preset 6363 each frame
// - crc sent without final inversion
// - ack with other number toggles ours
// - nak leaves block number unchanged
// - block number starts at one
`timescale 1ns/100ps
`include "block_framing_consts.svh"
module tag_end #(
   parameter int unsigned FWT_CYCLES = `FWT_BASE_US * `CLK_MHZ,
   parameter int unsigned FDT_W = 32,
   parameter logic [3:0] FWI = `FWI_DEFAULT
) (
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   block_link_if.tag LINK,
   input wire logic I_SEND_ACK,
   input wire logic I_CMD_BUSY,
   input wire logic [7:0] I_WTX,
   output logic [3:0] O_FWI,
   output logic O_BLOCK_NUM,
   output logic O_I_RX,
   output logic O_ACK_RX,
   output logic O_NAK_RX,
   output logic O_WTX_OK,
   output logic O_STANDBY,
   output logic O_CRC_ERR,
   output logic [FDT_W-1:0] O_TEMP_FRAME_DELAY
);
   block_framing_pkg::tag_state_t state_reg;
   block_framing_pkg::tag_state_t state_next;
   block_framing_pkg::kind_t rx_kind;
   logic [15:0] rx_crc_reg;
   logic [15:0] rx_crc_in;
   logic [15:0] rx_crc_next;
   logic [3:0] rx_cnt_reg;
   logic [7:0] rx_buf_reg [0:`RX_BUF_DEPTH-1];
   logic rx_done;
   logic rx_good;
   logic [7:0] rx_wtx;
   logic [FDT_W-1:0] cnt_reg;
   logic [FDT_W-1:0] limit_reg;
   logic [FDT_W-1:0] ext_limit;
   logic [7:0] wtx_sent_reg;
   logic [7:0] wtx_mult;
   logic wtx_pend_reg;
   logic ack_pend_reg;
   logic bn_reg;
   logic cmd_busy_q;
   logic wtx_fire;
   logic echo_ok;
   logic cmd_end;
   logic tx_start;
   logic tx_busy;
   logic [1:0] tx_len;
   logic [7:0] tx_b0;
   logic [7:0] tx_b1;

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   always_comb
   begin
      rx_crc_in = (rx_cnt_reg == 4'h0) ? `CRC_PRESET : rx_crc_reg;
      rx_crc_next = block_framing_pkg::crc_byte(rx_crc_in, LINK.r2t_data);
      rx_done = LINK.r2t_valid & LINK.r2t_last;
      // residue of a clean frame is zero because nothing is inverted
      rx_good = rx_done & (rx_crc_next == `CRC_RESIDUE) & (rx_cnt_reg >= `CRC_BYTES);
      rx_kind = block_framing_pkg::KIND_NONE;
      if (rx_good && state_reg != block_framing_pkg::ST_STANDBY)
         rx_kind = block_framing_pkg::decode_pcb(rx_buf_reg[0], rx_cnt_reg - 4'h1);
      rx_wtx = block_framing_pkg::wtx_field(rx_buf_reg[0], rx_buf_reg[1], rx_buf_reg[2]);
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rx_cnt_reg <= 4'h0;
         rx_crc_reg <= `CRC_PRESET;
      end
      else if (I_CE && LINK.r2t_valid)
      begin
         rx_crc_reg <= rx_crc_next;
         if (LINK.r2t_last)
            rx_cnt_reg <= 4'h0;
         else if (rx_cnt_reg != `RX_CNT_MAX)
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
   end

   // only the first three bytes of a frame are kept; bytes beyond them are checked, not stored
   for (genvar g = 0; g < `RX_BUF_DEPTH; g++)
   begin : g_rx_buf
      always_ff @(posedge I_MCLK or negedge I_RST_N)
      begin
         if (!I_RST_N)
            rx_buf_reg[g] <= 8'h00;
         else if (I_CE && LINK.r2t_valid && !LINK.r2t_last && rx_cnt_reg == 4'(g))
            rx_buf_reg[g] <= LINK.r2t_data;
      end
   end

   // ----------------------------------------
   // session state
   // ----------------------------------------
   always_comb
   begin
      cmd_end = cmd_busy_q & ~I_CMD_BUSY;
      wtx_fire = (state_reg == block_framing_pkg::ST_ACTIVE) & I_CMD_BUSY
                 & (cnt_reg >= limit_reg) & (rx_kind != block_framing_pkg::KIND_DES);
      echo_ok = (state_reg == block_framing_pkg::ST_WTX_WAIT)
                & (rx_kind == block_framing_pkg::KIND_WTX) & (rx_wtx == wtx_sent_reg);
      wtx_mult = (wtx_sent_reg == 8'h00) ? 8'h01 : wtx_sent_reg;
      ext_limit = FDT_W'(wtx_mult) * FDT_W'(FWT_CYCLES);
      state_next = state_reg;
      case (state_reg)
         block_framing_pkg::ST_ACTIVE:
         begin
            if (rx_kind == block_framing_pkg::KIND_DES)
               state_next = block_framing_pkg::ST_STANDBY;
            else if (wtx_fire)
               state_next = block_framing_pkg::ST_WTX_WAIT;
         end
         block_framing_pkg::ST_WTX_WAIT:
         begin
            if (rx_kind == block_framing_pkg::KIND_DES)
               state_next = block_framing_pkg::ST_STANDBY;
            else if (echo_ok || !I_CMD_BUSY)
               state_next = block_framing_pkg::ST_ACTIVE;
         end
         block_framing_pkg::ST_STANDBY:
            state_next = block_framing_pkg::ST_STANDBY;
         default:
            state_next = block_framing_pkg::ST_ACTIVE;
      endcase
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         state_reg <= block_framing_pkg::ST_ACTIVE;
         cmd_busy_q <= 1'b0;
      end
      else if (I_CE)
      begin
         state_reg <= state_next;
         cmd_busy_q <= I_CMD_BUSY;
      end
   end

   // ----------------------------------------
   // waiting time
   // ----------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         cnt_reg <= '0;
         limit_reg <= FDT_W'(FWT_CYCLES);
         wtx_sent_reg <= 8'h00;
      end
      else if (I_CE)
      begin
         if (wtx_fire)
            wtx_sent_reg <= I_WTX & `WTX_MULT_MASK;
         if (cmd_end || state_reg == block_framing_pkg::ST_STANDBY)
         begin
            cnt_reg <= '0;
            limit_reg <= FDT_W'(FWT_CYCLES);
         end
         else if (echo_ok)
         begin
            cnt_reg <= '0;
            limit_reg <= ext_limit;
         end
         else if (wtx_fire)
            cnt_reg <= '0;
         else if (I_CMD_BUSY && state_reg == block_framing_pkg::ST_ACTIVE)
            cnt_reg <= cnt_reg + FDT_W'(1);
      end
   end

   // ----------------------------------------
   // block number
   // ----------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         bn_reg <= 1'b1;
      else if (I_CE)
      begin
         if (rx_kind == block_framing_pkg::KIND_I)
            bn_reg <= ~bn_reg;
         else if (rx_kind == block_framing_pkg::KIND_ACK && rx_buf_reg[0][`PCB_BN_BIT] != bn_reg)
            bn_reg <= ~bn_reg;
         // a nak falls through and keeps the number
      end
   end

   // ----------------------------------------
   // transmit requests
   // ----------------------------------------
   // wtx goes first: a late extension would miss the reader's deadline
   always_comb
   begin
      tx_start = ~tx_busy & (wtx_pend_reg | ack_pend_reg)
                 & (state_reg != block_framing_pkg::ST_STANDBY);
      if (wtx_pend_reg)
      begin
         tx_len = `TX_LEN_TWO;
         tx_b0 = `PCB_WTX_NODID;
         tx_b1 = wtx_sent_reg;
      end
      else
      begin
         tx_len = `TX_LEN_ONE;
         tx_b0 = `PCB_ACK_NODID | {7'h00, bn_reg};
         tx_b1 = 8'h00;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         wtx_pend_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
      end
      else if (I_CE)
      begin
         if (state_reg == block_framing_pkg::ST_STANDBY)
         begin
            wtx_pend_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
         end
         else
         begin
            if (wtx_fire)
               wtx_pend_reg <= 1'b1;
            else if (tx_start && wtx_pend_reg)
               wtx_pend_reg <= 1'b0;
            if (I_SEND_ACK)
               ack_pend_reg <= 1'b1;
            else if (tx_start && !wtx_pend_reg)
               ack_pend_reg <= 1'b0;
         end
      end
   end

   block_tx u_tx (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_start(tx_start),
      .i_len(tx_len),
      .i_b0(tx_b0),
      .i_b1(tx_b1),
      .i_b2(8'h00),
      .o_data(LINK.t2r_data),
      .o_valid(LINK.t2r_valid),
      .o_last(LINK.t2r_last),
      .o_busy(tx_busy)
   );

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_FWI <= `FWI_DEFAULT;
         O_I_RX <= 1'b0;
         O_ACK_RX <= 1'b0;
         O_NAK_RX <= 1'b0;
         O_WTX_OK <= 1'b0;
         O_STANDBY <= 1'b0;
         O_CRC_ERR <= 1'b0;
      end
      else if (I_CE)
      begin
         O_FWI <= FWI;
         O_I_RX <= (rx_kind == block_framing_pkg::KIND_I);
         O_ACK_RX <= (rx_kind == block_framing_pkg::KIND_ACK);
         O_NAK_RX <= (rx_kind == block_framing_pkg::KIND_NAK);
         O_WTX_OK <= echo_ok;
         O_STANDBY <= (state_next == block_framing_pkg::ST_STANDBY);
         O_CRC_ERR <= rx_done & ~rx_good;
      end
   end

   assign O_BLOCK_NUM = bn_reg;
   assign O_TEMP_FRAME_DELAY = limit_reg;
endmodule // tag_end

/* design/reader_end.sv */
// reader end of the block framer: sends ack, nak, deselect; echoes wtx
// assumes requests are pulsed only while O_BUSY is low
`timescale 1ns/100ps
`include "block_framing_consts.svh"
module reader_end #(
   parameter int unsigned FWT_CYCLES = `FWT_BASE_US * `CLK_MHZ,
   parameter int unsigned FDT_W = 32
) (
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   block_link_if.reader LINK,
   input wire logic I_SEND_ACK,
   input wire logic I_SEND_NAK,
   input wire logic I_SEND_DES,
   input wire logic I_BLOCK_NUM,
   input wire logic I_ACCEPT_WTX,
   output logic O_BUSY,
   output logic O_ACK_RX,
   output logic O_RX_BLOCK_NUM,
   output logic O_WTX_RX,
   output logic [7:0] O_WTX,
   output logic O_CRC_ERR,
   output logic [FDT_W-1:0] O_TEMP_FRAME_DELAY
);
   block_framing_pkg::kind_t rx_kind;
   logic [15:0] rx_crc_reg;
   logic [15:0] rx_crc_next;
   logic [3:0] rx_cnt_reg;
   logic [7:0] rx_buf_reg [0:`RX_BUF_DEPTH-1];
   logic rx_done;
   logic rx_good;
   logic [7:0] rx_wtx;
   logic [7:0] wtx_mult;
   logic echo_pend_reg;
   logic tx_start;
   logic [1:0] tx_len;
   logic [7:0] tx_b0;

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   always_comb
   begin
      rx_crc_next = block_framing_pkg::crc_byte(
         (rx_cnt_reg == 4'h0) ? `CRC_PRESET : rx_crc_reg, LINK.t2r_data);
      rx_done = LINK.t2r_valid & LINK.t2r_last;
      rx_good = rx_done & (rx_crc_next == `CRC_RESIDUE) & (rx_cnt_reg >= `CRC_BYTES);
      rx_kind = rx_good ? block_framing_pkg::decode_pcb(rx_buf_reg[0], rx_cnt_reg - 4'h1)
                        : block_framing_pkg::KIND_NONE;
      rx_wtx = block_framing_pkg::wtx_field(rx_buf_reg[0], rx_buf_reg[1], rx_buf_reg[2]);
      wtx_mult = ((rx_wtx & `WTX_MULT_MASK) == 8'h00) ? 8'h01 : (rx_wtx & `WTX_MULT_MASK);
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rx_cnt_reg <= 4'h0;
         rx_crc_reg <= `CRC_PRESET;
      end
      else if (I_CE && LINK.t2r_valid)
      begin
         rx_crc_reg <= rx_crc_next;
         if (LINK.t2r_last)
            rx_cnt_reg <= 4'h0;
         else if (rx_cnt_reg != `RX_CNT_MAX)
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
   end

   for (genvar g = 0; g < `RX_BUF_DEPTH; g++)
   begin : g_rx_buf
      always_ff @(posedge I_MCLK or negedge I_RST_N)
      begin
         if (!I_RST_N)
            rx_buf_reg[g] <= 8'h00;
         else if (I_CE && LINK.t2r_valid && !LINK.t2r_last && rx_cnt_reg == 4'(g))
            rx_buf_reg[g] <= LINK.t2r_data;
      end
   end

   // ----------------------------------------
   // transmit selection
   // ----------------------------------------
   // echo first, then deselect, nak, ack
   always_comb
   begin
      tx_start = ~O_BUSY & (echo_pend_reg | I_SEND_DES | I_SEND_NAK | I_SEND_ACK);
      tx_len = echo_pend_reg ? `TX_LEN_TWO : `TX_LEN_ONE;
      if (echo_pend_reg)
         tx_b0 = `PCB_WTX_NODID;
      else if (I_SEND_DES)
         tx_b0 = `PCB_DES_NODID;
      else if (I_SEND_NAK)
         tx_b0 = `PCB_NAK_NODID | {7'h00, I_BLOCK_NUM};
      else
         tx_b0 = `PCB_ACK_NODID | {7'h00, I_BLOCK_NUM};
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         echo_pend_reg <= 1'b0;
         O_WTX <= 8'h00;
         O_TEMP_FRAME_DELAY <= FDT_W'(FWT_CYCLES);
      end
      else if (I_CE)
      begin
         if (rx_kind == block_framing_pkg::KIND_WTX && I_ACCEPT_WTX)
         begin
            echo_pend_reg <= 1'b1;
            O_WTX <= rx_wtx;
            O_TEMP_FRAME_DELAY <= FDT_W'(wtx_mult) * FDT_W'(FWT_CYCLES);
         end
         else if (tx_start && echo_pend_reg)
            echo_pend_reg <= 1'b0;
         else if (tx_start)
            O_TEMP_FRAME_DELAY <= FDT_W'(FWT_CYCLES);
      end
   end

   block_tx u_tx (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_start(tx_start),
      .i_len(tx_len),
      .i_b0(tx_b0),
      .i_b1(O_WTX),
      .i_b2(8'h00),
      .o_data(LINK.r2t_data),
      .o_valid(LINK.r2t_valid),
      .o_last(LINK.r2t_last),
      .o_busy(O_BUSY)
   );

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_ACK_RX <= 1'b0;
         O_RX_BLOCK_NUM <= 1'b0;
         O_WTX_RX <= 1'b0;
         O_CRC_ERR <= 1'b0;
      end
      else if (I_CE)
      begin
         O_ACK_RX <= (rx_kind == block_framing_pkg::KIND_ACK);
         if (rx_kind == block_framing_pkg::KIND_ACK)
            O_RX_BLOCK_NUM <= rx_buf_reg[0][`PCB_BN_BIT];
         O_WTX_RX <= (rx_kind == block_framing_pkg::KIND_WTX);
         O_CRC_ERR <= rx_done & ~rx_good;
      end
   end
endmodule // reader_end

/* tb/contactless_block_framing_assertions.sv */
// checker: frame shape and control bytes on the link
// assumes both ends run on I_MCLK
`timescale 1ns/100ps
module contactless_block_framing_assertions (
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire logic [7:0] r2t_data,
   input wire logic r2t_valid,
   input wire logic r2t_last,
   input wire logic [7:0] t2r_data,
   input wire logic t2r_valid,
   input wire logic t2r_last
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   property p_tn; $rose(t2r_valid) |-> t2r_valid[*3]; endproperty
   a_tn: assert property (p_tn) else $error("short frame");
   property p_tk; $rose(t2r_valid) |-> t2r_data[7:4] != 4'hb; endproperty
   a_tk: assert property (p_tk) else $error("tag nak");
   property p_tr; $rose(t2r_valid) && t2r_data[7:6] == 2'b10
      |-> t2r_data[5] && t2r_data[2:1] == 2'b01 ##2 t2r_last; endproperty
   a_tr: assert property (p_tr) else $error("bad ack");
   property p_ts; $rose(t2r_valid) && t2r_data[7:6] == 2'b11 |-> t2r_data == 8'hf2; endproperty
   a_ts: assert property (p_ts) else $error("bad s pcb");
   property p_tw; $rose(t2r_valid) && t2r_data == 8'hf2 |-> !t2r_last[*3] ##1 t2r_last; endproperty
   a_tw: assert property (p_tw) else $error("bad wtx len");
   property p_rp; $rose(r2t_valid) |-> r2t_data[2:1] == 2'b01; endproperty
   a_rp: assert property (p_rp) else $error("bad pcb");
   property p_rd; $rose(r2t_valid) && r2t_data == 8'hc2 |-> ##2 r2t_last; endproperty
   a_rd: assert property (p_rd) else $error("bad des len");
   property p_re; $rose(r2t_valid) && r2t_data == 8'hf2 |-> ##3 r2t_last; endproperty
   a_re: assert property (p_re) else $error("bad echo len");
   c_ack: cover property ($rose(t2r_valid) && t2r_data[7:4] == 4'ha);
   c_wtx: cover property ($rose(r2t_valid) && r2t_data == 8'hf2);
   c_des: cover property ($rose(r2t_valid) && r2t_data == 8'hc2);
endmodule // contactless_block_framing_assertions

/* tb/tb_contactless_block_framing.sv */
// bench: tag end and reader end on one link
// assumes a base wait of 40 cycles to keep the run short
`timescale 1ns/100ps
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s exp %0h got %0h", w, e, g); end end
module tb_contactless_block_framing;
   localparam int FWT = 40;
   logic clk = 0, rst_n = 0, ta = 0, busy = 0, ra = 0, rn = 0, rd = 0, r_bn = 0, acc = 1;
   logic bn, tack, tnak, wok, stby, rack, rbn, terr, rwx;
   logic [3:0] fwi;
   logic [7:0] rwtx;
   logic [31:0] tdel, rdel;
   logic [15:0] tc = 16'h6363;
   int mismatches = 0, comparisons = 0, nt = 0, nn = 0, nw = 0, nr = 0, ne = 0, nx = 0;
   block_link_if lnk ();
   always #10 clk = ~clk;
   tag_end #(.FWT_CYCLES(FWT)) i_tag_end (.I_MCLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
      .LINK(lnk), .I_SEND_ACK(ta), .I_CMD_BUSY(busy), .I_WTX(8'h03), .O_FWI(fwi),
      .O_BLOCK_NUM(bn), .O_I_RX(), .O_ACK_RX(tack), .O_NAK_RX(tnak), .O_WTX_OK(wok),
      .O_STANDBY(stby), .O_CRC_ERR(terr), .O_TEMP_FRAME_DELAY(tdel));
   reader_end #(.FWT_CYCLES(FWT)) i_reader_end (.I_MCLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
      .LINK(lnk), .I_SEND_ACK(ra), .I_SEND_NAK(rn), .I_SEND_DES(rd), .I_BLOCK_NUM(r_bn),
      .I_ACCEPT_WTX(acc), .O_BUSY(), .O_ACK_RX(rack), .O_RX_BLOCK_NUM(rbn),
      .O_WTX_RX(rwx), .O_WTX(rwtx), .O_CRC_ERR(), .O_TEMP_FRAME_DELAY(rdel));
   contactless_block_framing_assertions i_chk (.I_MCLK(clk), .I_RST_N(rst_n),
      .r2t_data(lnk.r2t_data), .r2t_valid(lnk.r2t_valid), .r2t_last(lnk.r2t_last),
      .t2r_data(lnk.t2r_data), .t2r_valid(lnk.t2r_valid), .t2r_last(lnk.t2r_last));
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
      c ^= {8'h00, d};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      return c;
   endfunction
   // crc goes low byte first, so a good frame leaves zero
   always @(posedge clk)
   begin
      nt += tack;
      nn += tnak;
      nw += wok;
      nr += rack;
      ne += terr;
      nx += rwx;
      if (lnk.t2r_valid) tc = crc(tc, lnk.t2r_data);
      if (lnk.t2r_last)
      begin
         `CHK("crc", 16'h0000, tc)
         tc = 16'h6363;
      end
   end
   task automatic pulse(ref logic s, input logic b);
      @(posedge clk);
      #1 s = 1;
      r_bn = b;
      @(posedge clk);
      #1 s = 0;
      repeat (12) @(posedge clk);
      #1;
   endtask
   task s_blocks();
      `CHK("bn", 1'b1, bn)
      `CHK("fwi", 4'h7, fwi)
      pulse(ra, 0);
      `CHK("ack rx", 1, nt)
      `CHK("bn", 1'b0, bn)
      pulse(ra, 0);
      `CHK("bn", 1'b0, bn)
      pulse(rn, 1);
      `CHK("nak rx", 1, nn)
      `CHK("bn", 1'b0, bn)
      pulse(ta, 0);
      `CHK("tag ack", 1, nr)
      `CHK("ack bn", 1'b0, rbn)
   endtask
   task s_wtx();
      busy = 1;
      repeat (80) @(posedge clk);
      #1;
      `CHK("wtx ok", 1, nw)
      `CHK("wtx", 8'h03, rwtx)
      `CHK("delay", 32'(3 * FWT), tdel)
      `CHK("rdelay", 32'(3 * FWT), rdel)
      busy = 0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("delay", 32'(FWT), tdel)
   endtask
   // reader refuses the extension: tag must keep the base limit
   task s_rej();
      acc = 0;
      busy = 1;
      repeat (80) @(posedge clk);
      #1;
      `CHK("wtx rx", 2, nx)
      `CHK("wtx ok", 1, nw)
      `CHK("delay", 32'(FWT), tdel)
      busy = 0;
      acc = 1;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task s_des();
      pulse(rd, 0);
      `CHK("standby", 1'b1, stby)
      `CHK("rdelay", 32'(FWT), rdel)
      pulse(ra, 1);
      `CHK("ack rx", 2, nt)
      `CHK("bn", 1'b0, bn)
      `CHK("crc err", 0, ne)
      // new activation: reset mid-run
      rst_n = 0;
      @(posedge clk);
      #1 rst_n = 1;
      @(posedge clk);
      #1;
      `CHK("standby", 1'b0, stby)
      `CHK("bn", 1'b1, bn)
   endtask
   task conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      repeat (2) @(posedge clk);
      #1;
      s_blocks();
      s_wtx();
      s_rej();
      s_des();
      conclude();
   end
   initial
   begin
      #50000;
      mismatches++;
      conclude();
   end
endmodule // tb_contactless_block_framing
